/* design/rpo_pkg.sv */
`default_nettype none
package rpo_pkg;
  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // Control fields
  localparam int CTRL_PIXSEL_BIT = 0;
  localparam int CTRL_CKPOL_BIT  = 1;
  localparam int CTRL_FMT_BIT    = 2;
  localparam int CTRL_WIDTH      = 3;

  // Status fields
  localparam int STAT_POWERED_BIT = 0;
  localparam int STAT_DRIVING_BIT = 1;
  localparam int STAT_DE_BIT      = 2;

  // ----------------------------------------------------------------
  // Pixel bus layout
  // ----------------------------------------------------------------
  localparam int BUS_W   = 36;
  localparam int PIX1_W  = 24;
  localparam int HALF_W  = 18;
  localparam int CTL_W   = 3;
  localparam logic [11:0] UPPER_ZERO = 12'h000;
endpackage
`default_nettype wire

/* design/rpo_top.sv */
// Functional notes
// (R1) Pixel bus changes in step with output clock
// (R2) One-pixel mode: upper twelve bits low
// (R3) Two-pixel mode: even low half, odd high
// (R4) Either power-down floats bus, clock, enable, general_ctrl_out_3
// (R5) Floated outputs weakly pulled low
// (R6) General_ctrl_out_1 obeys only full power-down
// (R7) Syncs and general_ctrl_out_2, general_ctrl_out_3 share output timing
// (R8) Polarity selects clock inversion and latching edge
// (R9) Format select stops clock low while enable low
// (R10) Full power-down halts logic; output power-down floats
// (R11) Pixel numbering restarts at enable rising edge
//
// The APB interface to the registers and the register addresses were decided locally.
`default_nettype none
module rpo_top (
  input  wire logic        clk_i,                 // APB clock, 100 MHz
  input  wire logic        resetn_i,              // Async reset, low
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB direction
  input  wire logic [7:0]  paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic      [31:0] prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error
  input  wire logic        link_clk_i,            // Pixel domain clock
  input  wire logic [23:0] in_pixel_i,            // Pixel from decoder
  input  wire logic        in_de_i,               // Enable from decoder
  input  wire logic        in_hsync_i,            // Hsync from decoder
  input  wire logic        in_vsync_i,            // Vsync from decoder
  input  wire logic [2:0]  in_ctl_i,              // Ctl 3..1 in
  output logic             in_ready_o,            // Pixel taken
  input  wire logic        full_power_down_n_i,   // Full power-down pin
  input  wire logic        output_power_down_n_i, // Output power-down pin
  output logic [35:0]      pixel_out_bus_o,       // Pixel bus value
  output logic             pixel_out_bus_oe_n_o,  // Bus enable, low
  output logic             pixel_out_clock_o,     // Output clock value
  output logic             pixel_out_clock_oe_n_o,// Clock enable, low
  output logic             display_enable_out_o,  // Enable value
  output logic             display_enable_oe_n_o, // Enable oe, low
  output logic             hsync_out_o,           // Horizontal sync
  output logic             vsync_out_o,           // Vertical sync
  output logic             general_ctrl_out_1_o,  // General_ctrl_out_1 value
  output logic             general_ctrl_1_oe_n_o, // General_ctrl_out_1 oe, low
  output logic             general_ctrl_out_2_o,  // General_ctrl_out_2 value
  output logic             general_ctrl_out_3_o,  // General_ctrl_out_3 value
  output logic             general_ctrl_3_oe_n_o, // General_ctrl_out_3 oe, low
  output logic             pull_down_en_o         // Weak pull-downs on
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [rpo_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [1:0] pdf_apb_sync;
  logic [1:0] pdo_apb_sync;
  logic [1:0] de_apb_sync;
  logic       apb_hit;
  logic [31:0] next_prdata;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == rpo_pkg::ADDR_CTRL) || (a == rpo_pkg::ADDR_STATUS);
  endfunction

  assign apb_hit = mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == rpo_pkg::ADDR_CTRL) begin
      next_prdata[rpo_pkg::CTRL_WIDTH-1:0] = ctrl;
    end else if (paddr == rpo_pkg::ADDR_STATUS) begin
      next_prdata[rpo_pkg::STAT_POWERED_BIT] = pdf_apb_sync[1];
      next_prdata[rpo_pkg::STAT_DRIVING_BIT] =
        pdf_apb_sync[1] & pdo_apb_sync[1];
      next_prdata[rpo_pkg::STAT_DE_BIT] = de_apb_sync[1];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= rpo_pkg::CTRL_RESET[rpo_pkg::CTRL_WIDTH-1:0];
    end else if (psel && penable && pwrite &&
                 paddr == rpo_pkg::ADDR_CTRL) begin
      ctrl <= pwdata[rpo_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Read data captured in setup so it is stable through access
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Pins and the pixel domain enable, into the APB domain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pdf_apb_sync <= 2'h0;
      pdo_apb_sync <= 2'h0;
      de_apb_sync  <= 2'h0;
    end else begin
      pdf_apb_sync <= {pdf_apb_sync[0], full_power_down_n_i};
      pdo_apb_sync <= {pdo_apb_sync[0], output_power_down_n_i};
      de_apb_sync  <= {de_apb_sync[0], display_enable_out_o};
    end
  end

  // ----------------------------------------------------------------
  // Pixel domain reset and crossings
  // ----------------------------------------------------------------
  logic [1:0] lrst_sync;
  logic       link_rst_n;
  logic [1:0] two_sync;
  logic [1:0] pol_sync;
  logic [1:0] fmt_sync;
  logic [1:0] pdf_sync;
  logic [1:0] pdo_sync;
  logic       two_s;
  logic       pol_s;
  logic       fmt_s;
  logic       pdf_s;
  logic       pdo_s;

  // Assert at once, release on the pixel clock
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_sync <= 2'h0;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_sync[1];

  // Control bits change rarely; each is a quasi-static level
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      two_sync <= 2'h0;
      pol_sync <= 2'h0;
      fmt_sync <= 2'h0;
      pdf_sync <= 2'h0;
      pdo_sync <= 2'h0;
    end else begin
      two_sync <= {two_sync[0], ctrl[rpo_pkg::CTRL_PIXSEL_BIT]};
      pol_sync <= {pol_sync[0], ctrl[rpo_pkg::CTRL_CKPOL_BIT]};
      fmt_sync <= {fmt_sync[0], ctrl[rpo_pkg::CTRL_FMT_BIT]};
      pdf_sync <= {pdf_sync[0], full_power_down_n_i};
      pdo_sync <= {pdo_sync[0], output_power_down_n_i};
    end
  end
  assign two_s = two_sync[1];
  assign pol_s = pol_sync[1];
  assign fmt_s = fmt_sync[1];
  assign pdf_s = pdf_sync[1];
  assign pdo_s = pdo_sync[1];

  // ----------------------------------------------------------------
  // Pixel pipeline
  // ----------------------------------------------------------------
  logic                       oclk;
  logic                       next_oclk;
  logic                       ock_q;
  logic                       de_seen;
  logic                       restart;
  logic                       launch;
  logic                       next_de;
  logic [rpo_pkg::HALF_W-1:0] even_hold;
  logic [rpo_pkg::BUS_W-1:0]  data_q;
  logic                       de_q;
  logic                       hs_q;
  logic                       vs_q;
  logic [rpo_pkg::CTL_W-1:0]  ctl_q;
  logic                       drv_q;

  // Odd slot is oclk low; enable rising there re-seeds the even slot
  assign restart = two_s & pdf_s & ~oclk & in_de_i & ~de_seen; // see (R11)
  assign launch  = pdf_s & ~oclk & ~restart;                   // see (R1)
  assign in_ready_o = pdf_s & (two_s | ~oclk);
  assign next_oclk  = !pdf_s ? 1'b0 : (restart ? oclk : ~oclk);
  assign next_de    = !pdf_s ? 1'b0 : (launch ? in_de_i : de_q);

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oclk <= 1'b0;
    end else begin
      oclk <= next_oclk; // see (R10)
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      de_seen   <= 1'b0;
      even_hold <= '0;
    end else if (!pdf_s) begin
      de_seen   <= 1'b0;
      even_hold <= '0;
    end else if (in_ready_o) begin
      de_seen <= in_de_i;
      if (two_s && (oclk || restart)) begin
        even_hold <= in_pixel_i[rpo_pkg::HALF_W-1:0]; // see (R3)
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      data_q <= '0;
    end else if (!pdf_s) begin
      data_q <= '0; // see (R10)
    end else if (launch) begin
      if (two_s) begin
        data_q <= {in_pixel_i[rpo_pkg::HALF_W-1:0], even_hold}; // see (R3)
      end else begin
        data_q <= {rpo_pkg::UPPER_ZERO, in_pixel_i}; // see (R2)
      end
    end
  end

  // Controls launch with the pixel they travel beside
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      de_q  <= 1'b0;
      hs_q  <= 1'b0;
      vs_q  <= 1'b0;
      ctl_q <= '0;
    end else begin
      de_q <= next_de;
      if (!pdf_s) begin
        hs_q  <= 1'b0;
        vs_q  <= 1'b0;
        ctl_q <= '0;
      end else if (launch) begin
        hs_q  <= in_hsync_i; // see (R7)
        vs_q  <= in_vsync_i;
        ctl_q <= in_ctl_i;
      end
    end
  end

  // Clock rises with new data when polarity is clear and falls when it is set; panel latches the opposite edge
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ock_q <= 1'b0;
    end else if (!pdf_s || (fmt_s && !next_de)) begin
      ock_q <= 1'b0; // see (R9)
    end else begin
      ock_q <= next_oclk ^ pol_s; // see (R8)
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      drv_q <= 1'b0;
    end else begin
      drv_q <= pdf_s & pdo_s; // see (R4)
    end
  end

  // ----------------------------------------------------------------
  // Pads
  // ----------------------------------------------------------------
  // Undriven pads show low: pad pull-down stands in for the float
  assign pixel_out_bus_o        = drv_q ? data_q : '0;  // see (R5)
  assign pixel_out_bus_oe_n_o   = ~drv_q;               // see (R4)
  assign pixel_out_clock_o      = drv_q & ock_q;
  assign pixel_out_clock_oe_n_o = ~drv_q;
  assign display_enable_out_o   = drv_q & de_q;
  assign display_enable_oe_n_o  = ~drv_q;
  assign general_ctrl_out_3_o   = drv_q & ctl_q[2];
  assign general_ctrl_3_oe_n_o  = ~drv_q;
  assign pull_down_en_o         = ~drv_q;               // see (R5)
  assign general_ctrl_1_oe_n_o  = ~pdf_s;               // see (R6)
  assign general_ctrl_out_1_o   = pdf_s & ctl_q[0];
  assign general_ctrl_out_2_o   = ctl_q[1];             // see (R7)
  assign hsync_out_o            = hs_q;
  assign vsync_out_o            = vs_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!link_rst_n);

  // Full power-down clears the bus on purpose, so it is left out here
  property p_bus_steady;
    (pdf_s && !launch) |=> $stable(data_q);
  endproperty
  a_bus_steady: assert property (p_bus_steady) // see (R1)
    else $error("Pixel bus changed without launch");

  property p_one_upper;
    (launch && !two_s) |=> data_q[35:24] == 12'h000 &&
      data_q[23:0] == $past(in_pixel_i);
  endproperty
  a_one_upper: assert property (p_one_upper) // see (R2)
    else $error("One-pixel mode bus wrong");

  property p_two_halves;
    (launch && two_s) |=> data_q[17:0] == $past(even_hold) &&
      data_q[35:18] == $past(in_pixel_i[17:0]);
  endproperty
  a_two_halves: assert property (p_two_halves) // see (R3)
    else $error("Two-pixel halves misplaced");

  property p_float;
    (!pdf_s || !pdo_s) |=> pixel_out_bus_oe_n_o && pixel_out_clock_oe_n_o
      && display_enable_oe_n_o && general_ctrl_3_oe_n_o;
  endproperty
  a_float: assert property (p_float) // see (R4)
    else $error("Outputs driven during power-down");

  property p_pull;
    pixel_out_bus_oe_n_o |-> pull_down_en_o && pixel_out_bus_o == '0
      && !pixel_out_clock_o && !display_enable_out_o;
  endproperty
  a_pull: assert property (p_pull) // see (R5)
    else $error("Floated output not pulled low");

  property p_general_ctrl_out_1;
    (pdf_s && !pdo_s) |-> !general_ctrl_1_oe_n_o;
  endproperty
  a_general_ctrl_out_1: assert property (p_general_ctrl_out_1) // see (R6)
    else $error("General_ctrl_out_1 floated by output power-down");

  property p_clk_edge;
    (launch && !fmt_s) |=> ock_q == !$past(pol_s);
  endproperty
  a_clk_edge: assert property (p_clk_edge) // see (R8)
    else $error("Clock level wrong after launch");

  property p_clk_stop;
    (fmt_s && !next_de) |=> !ock_q && !de_q;
  endproperty
  a_clk_stop: assert property (p_clk_stop) // see (R9)
    else $error("Clock ran while enable low");

  property p_halt;
    !pdf_s |=> !oclk && !ock_q && data_q == '0 && !de_q;
  endproperty
  a_halt: assert property (p_halt) // see (R10)
    else $error("Logic active in full power-down");

  property p_restart;
    restart |=> !oclk && even_hold == $past(in_pixel_i[17:0]) && launch;
  endproperty
  a_restart: assert property (p_restart) // see (R11)
    else $error("Even slot not re-seeded");

  c_two_launch: cover property (launch && two_s && in_de_i);
  c_restart:    cover property (restart);
  c_clk_stop:   cover property (fmt_s && de_q ##1 !de_q);
  c_out_pd:     cover property (pdf_s && !pdo_s);

endmodule
`default_nettype wire

/* sim/rpo_panel_model.sv */
`default_nettype none
module rpo_panel_model (
  input  wire logic        pclk_i,  // Output clock wire
  input  wire logic        pol_i,   // High: latch on rising edge
  input  wire logic [35:0] bus_i,   // Pixel bus wire
  input  wire logic [4:0]  ctl_i,   // Enable, syncs, general_ctrl_out_2, general_ctrl_out_3 wires
  output var  logic [35:0] q_bus_o, // Latched bus
  output var  logic [4:0]  q_ctl_o, // Latched controls
  output var  int          lat_n_o  // Latch count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lat_n_o = 0;
  task automatic latch();
    q_bus_o = bus_i;
    q_ctl_o = ctl_i;
    lat_n_o = lat_n_o + 1;
  endtask
  // Latching on the wrong edge lands on the launch edge and races
  always @(posedge pclk_i) begin
    if (pol_i === 1'b1) latch();
  end
  always @(negedge pclk_i) begin
    if (pol_i === 1'b0) latch();
  end
endmodule
`default_nettype wire

/* sim/receiver_pixel_output_port_tb.sv */
`default_nettype none
module receiver_pixel_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, resetn_i = 1'b0, link_clk_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_ready_o, in_de_i, in_hsync_i, in_vsync_i;
  logic [17:0] cnt = 18'h0, prev;
  logic [23:0] in_pixel_i;
  logic [2:0] in_ctl_i;
  logic full_power_down_n_i = 1'b1, output_power_down_n_i = 1'b1;
  logic [35:0] pixel_out_bus_o, bus_w, q_bus, last_bus;
  logic pixel_out_bus_oe_n_o, pixel_out_clock_o, pixel_out_clock_oe_n_o;
  logic display_enable_out_o, display_enable_oe_n_o, hsync_out_o;
  logic vsync_out_o, general_ctrl_out_1_o, general_ctrl_1_oe_n_o;
  logic general_ctrl_out_2_o, general_ctrl_out_3_o, general_ctrl_3_oe_n_o;
  logic pull_down_en_o, pclk_w, de_w, c3_w, pol = 1'b0;
  logic [4:0] q_ctl, oe_all;
  int lat_n, mode = 0, cyc = 0, mismatches = 0, cmp_count = 0;
  bit pol_chk = 0, fmt_chk = 0, have_prev = 0;
  always #5 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #3 link_clk_i = ~link_clk_i;
  end
  // ------------------------------
  // Pixel source and pad wires
  // ------------------------------
  always @(posedge link_clk_i) if (in_ready_o === 1'b1) cnt <= cnt + 18'h1;
  assign in_pixel_i = {6'h2a, cnt};
  assign in_de_i = (cnt % 7) != 0;
  assign in_hsync_i = !in_de_i;
  assign in_vsync_i = cnt[3];
  assign in_ctl_i = {cnt[2], cnt[1], cnt[4]};
  // Floated pads read low only through the weak pull-downs
  assign bus_w = pixel_out_bus_oe_n_o ? (pull_down_en_o ? 36'h0 : 36'hz)
                                      : pixel_out_bus_o;
  assign pclk_w = pixel_out_clock_oe_n_o ? (pull_down_en_o ? 1'b0 : 1'bz)
                                         : pixel_out_clock_o;
  assign de_w = display_enable_oe_n_o ? (pull_down_en_o ? 1'b0 : 1'bz)
                                      : display_enable_out_o;
  assign c3_w = general_ctrl_3_oe_n_o ? (pull_down_en_o ? 1'b0 : 1'bz)
                                      : general_ctrl_out_3_o;
  assign oe_all = {pixel_out_bus_oe_n_o, pixel_out_clock_oe_n_o,
                   display_enable_oe_n_o, general_ctrl_3_oe_n_o,
                   general_ctrl_1_oe_n_o};
  rpo_top dut_u (
    .clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link_clk_i, .in_pixel_i, .in_de_i, .in_hsync_i,
    .in_vsync_i, .in_ctl_i, .in_ready_o, .full_power_down_n_i,
    .output_power_down_n_i, .pixel_out_bus_o, .pixel_out_bus_oe_n_o,
    .pixel_out_clock_o, .pixel_out_clock_oe_n_o, .display_enable_out_o,
    .display_enable_oe_n_o, .hsync_out_o, .vsync_out_o,
    .general_ctrl_out_1_o, .general_ctrl_1_oe_n_o, .general_ctrl_out_2_o,
    .general_ctrl_out_3_o, .general_ctrl_3_oe_n_o, .pull_down_en_o);
  rpo_panel_model panel_u (.pclk_i(pclk_w), .pol_i(pol), .bus_i(bus_w),
    .ctl_i({de_w, hsync_out_o, vsync_out_o, general_ctrl_out_2_o, c3_w}),
    .q_bus_o(q_bus), .q_ctl_o(q_ctl), .lat_n_o(lat_n));
  // ------------------------------
  // Checking helpers
  // ------------------------------
  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [4:0] exp_ctl(input logic [17:0] n);
    return {n % 7 != 0, n % 7 == 0, n[3], n[1], n[2]};
  endfunction
  // Let the latched copy settle before it is read
  always @(lat_n) begin
    #1;
    if (mode == 1) begin
      chk("upper bits", 36'h2a, 36'(q_bus[35:18]));
      if (have_prev)
        chk("step", 36'(prev + 18'h1), 36'(q_bus[17:0]));
      chk("controls", 36'(exp_ctl(q_bus[17:0])), 36'(q_ctl));
      chk("general_ctrl_out_1", 36'(q_bus[4]), 36'(general_ctrl_out_1_o));
      prev = q_bus[17:0];
      have_prev = 1'b1;
    end else if (mode == 2 && q_ctl[4] === 1'b1) begin
      chk("odd half", 36'(q_bus[17:0] + 18'h1),
          36'(q_bus[35:18]));
      chk("line phase", 36'h1, 36'(q_bus[17:0] % 7 % 2));
    end
  end
  always @(negedge link_clk_i) begin
    if (pol_chk && pixel_out_bus_o !== last_bus)
      chk("launch clock", 36'(!pol), 36'(pixel_out_clock_o));
    last_bus = pixel_out_bus_o;
    if (fmt_chk)
      chk("gated clock", 36'h0,
          36'(pixel_out_clock_o & !display_enable_out_o));
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic wait_link(input int n);
    repeat (n) @(negedge link_clk_i);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    apb(1'b0, rpo_pkg::ADDR_CTRL, 32'h0, rd, err);
    chk("ctrl reset", 36'(rpo_pkg::CTRL_RESET), 36'(rd));
    apb(1'b1, rpo_pkg::ADDR_CTRL, 32'hffff_fff8, rd, err);
    apb(1'b0, rpo_pkg::ADDR_CTRL, 32'h0, rd, err);
    chk("ctrl spare bits", 36'h0, 36'(rd));
    apb(1'b0, rpo_pkg::ADDR_STATUS, 32'h0, rd, err);
    chk("status powered", 36'h3, 36'(rd[1:0]));
    apb(1'b0, 8'h08, 32'h0, rd, err);
    chk("unmapped", 36'h1, {3'h0, rd, err});
    $display("Test registers done");
  endtask
  task automatic run_stream(input string nm, input logic [2:0] c,
                            input int m, input bit pc, input bit fc);
    logic [31:0] rd;
    logic        err;
    int          n0;
    mode = 0;
    apb(1'b1, rpo_pkg::ADDR_CTRL, {29'h0, c}, rd, err);
    pol = c[rpo_pkg::CTRL_CKPOL_BIT];
    wait_link(20);
    have_prev = 1'b0;
    n0 = lat_n;
    mode = m;
    pol_chk = pc;
    fmt_chk = fc;
    wait_link(200);
    mode = 0;
    pol_chk = 0;
    fmt_chk = 0;
    chk("latch count", 36'h1, 36'(lat_n - n0 > 40));
    $display("Test %s done", nm);
  endtask
  task automatic t_power();
    logic [31:0] rd;
    logic        err;
    @(posedge clk_i);
    output_power_down_n_i <= 1'b0;
    wait_link(10);
    chk("oe_n output pd", 36'h1e, 36'(oe_all));
    chk("bus wire", 36'h0, bus_w);
    chk("pulled wires", 36'h1,
        36'({pclk_w, de_w, c3_w, pull_down_en_o}));
    apb(1'b0, rpo_pkg::ADDR_STATUS, 32'h0, rd, err);
    chk("status output pd", 36'h1, 36'(rd[1:0]));
    full_power_down_n_i <= 1'b0;
    output_power_down_n_i <= 1'b1;
    wait_link(10);
    chk("oe_n full pd", 36'h1f, 36'(oe_all));
    apb(1'b0, rpo_pkg::ADDR_STATUS, 32'h0, rd, err);
    chk("status full pd", 36'h0, 36'(rd[1:0]));
    full_power_down_n_i <= 1'b1;
    wait_link(20);
    chk("oe_n driven", 36'h0, 36'(oe_all));
    $display("Test power-down done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_link(8);
    t_regs();
    run_stream("one pixel", 3'h0, 1, 1'b1, 1'b0);
    run_stream("two pixel", 3'h1, 2, 1'b1, 1'b0);
    run_stream("inverted", 3'h2, 1, 1'b1, 1'b0);
    run_stream("gated", 3'h4, 0, 1'b0, 1'b1);
    t_power();
    end_sim();
  end
endmodule
`default_nettype wire
